// file: core/dma_size_defs.svh
`ifndef DMA_SIZE_DEFS_SVH
`define DMA_SIZE_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFS_SIZE0    5'h00
`define OFS_MODE0    5'h04
`define OFS_SIZE1    5'h08
`define OFS_MODE1    5'h0c
`define OFS_IRQ_STAT 5'h10
`define OFS_IRQ_MASK 5'h14

// ==========================================================
// Mode control word fields
`define B_ENABLE   31
`define B_RUNNING  23
`define B_ERROR    19
`define B_SIZE_END 17
`define B_XFER_END 16
`define B_WIDTH    14
`define B_MODE     12
`define B_FACTOR   6
`define MODE_WMASK 32'hec00fbe7
`define MODE_RMASK 32'hec8bfbe7
`define FACTOR_AUTO 2'h2

// ==========================================================
// Reset values
`define MODE_RST 32'h00000000
`define HALF_RST 16'h0000
`define IRQ_RST  6'h00

`endif

// file: core/dma_size_pkg.sv
package dma_size_pkg;

  localparam int NUM_CH = 2;

  typedef logic [NUM_CH-1:0]      chan_t;
  typedef logic [NUM_CH-1:0][1:0] chan_field_t;

  typedef enum logic [1:0]
  {
    MdNormal = 2'h0,
    MdBlock  = 2'h1,
    MdRepeat = 2'h2,
    MdSpare  = 2'h3
  } xfer_mode_e;

  typedef struct packed
  {
    logic [15:0] reload;
    logic [15:0] remaining;
    logic        blockEnd;
  } size_state_s;

  typedef struct packed
  {
    logic [NUM_CH-1:0][31:0] mode;
    chan_t                   stopPend;
    chan_t                   act;
    chan_t                   startPls;
    chan_t                   blkDone;
    logic [NUM_CH-1:0][2:0]  flag;
    logic [NUM_CH-1:0][2:0]  armed;
    logic [5:0]              irqStat;
    logic [5:0]              irqMask;
    logic                    waitReq;
    logic [31:0]             rdData;
    logic                    irq;
  } ctrl_state_s;

endpackage

// file: core/size_counter_if.sv
`timescale 1ns/1ps
interface size_counter_if;
  logic        wrEn;
  logic [3:0]  be;
  logic [31:0] wrData;
  logic        running;
  logic        countOn;
  logic        strobe;
  logic [31:0] value;
  logic        blockEnd;

  modport ctrl
  (
    output wrEn, be, wrData, running, countOn, strobe,
    input  value, blockEnd
  );
  modport unit
  (
    input  wrEn, be, wrData, running, countOn, strobe,
    output value, blockEnd
  );
endinterface

// file: core/block_size_unit.sv
`timescale 1ns/1ps
`include "dma_size_defs.svh"
module block_size_unit
(
  input wire logic          clock,
  input wire logic          rst_b,
  size_counter_if.unit      sz
);
  import dma_size_pkg::*;

  size_state_s q;
  size_state_s d;

  // ==========================================================
  // Reload and remaining halves
  always_comb
  begin
    d          = q;
    d.blockEnd = 1'b0;
    if (sz.wrEn)
    begin
      if (!sz.running)
      begin
        if (sz.be[2]) d.reload[7:0]  = sz.wrData[23:16];
        if (sz.be[3]) d.reload[15:8] = sz.wrData[31:24];
      end
      if (sz.be[0]) d.remaining[7:0]  = sz.wrData[7:0];
      if (sz.be[1]) d.remaining[15:8] = sz.wrData[15:8];
    end
    // Counting only outside normal mode; a transfer wins over a write
    if (sz.countOn && sz.strobe)
    begin
      if (q.remaining == 16'h0001)
      begin
        d.remaining = q.reload;
        d.blockEnd  = 1'b1;
      end
      else
      begin
        // Zero wraps to 16'hffff: a full 65536-unit block
        d.remaining = q.remaining - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      q <= '{reload: `HALF_RST, remaining: `HALF_RST, blockEnd: 1'b0};
    else
      q <= d;
  end

  assign sz.value    = {q.reload, q.remaining};
  assign sz.blockEnd = q.blockEnd;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_unitBlock;
    sz.countOn && sz.strobe && q.remaining == 16'h0001 && q.reload == 16'h0001;
  endsequence

  a_reload_fixed: assert property ((sz.running && sz.wrEn) |=> q.reload == $past(q.reload))
    else $error("reload half changed while running");
  a_count_step: assert property ((sz.countOn && sz.strobe && q.remaining > 16'h0001)
    |=> q.remaining == $past(q.remaining) - 16'h0001 && !q.blockEnd)
    else $error("remaining half did not step by one");
  a_reload_load: assert property ((sz.countOn && sz.strobe && q.remaining == 16'h0001)
    |=> q.remaining == $past(q.reload) && q.blockEnd)
    else $error("remaining half not reloaded at block end");
  a_normal_hold: assert property ((!sz.countOn && !sz.wrEn) |=> $stable(q.remaining))
    else $error("remaining half moved outside repeat or block mode");
  a_unit_block: assert property (s_unitBlock |=> q.blockEnd && q.remaining == 16'h0001)
    else $error("size one did not end after one unit");
  a_zero_max: assert property ((sz.countOn && sz.strobe && q.remaining == 16'h0000)
    |=> q.remaining == 16'hffff && !q.blockEnd)
    else $error("size zero not treated as maximum");
endmodule

// file: core/dma_block_size_and_mode_control.sv
// Function
// - Size counter only counts in repeat/block mode (also counts in spare mode 3, every mode but normal)
// - Reload one means one access unit
// - Reload zero means maximum block size
// - Reload half fixed while channel operates
// - Remaining half drops one per transfer
// - Remaining reloads from reload half on the transfer at one
// - Sizes up to 65536 units, any width
// - Flags clear by zero write after read
// - Mode word bit layout as specified
// - Enable starts auto at once, else request
// - Block mode disable waits for block end
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dma_size_defs.svh"
module dma_block_size_and_mode_control
(
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic [4:0]                  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  input  wire logic [3:0]                  byteenable,
  output logic [31:0]                      readdata,
  output logic                             waitrequest,
  output logic                             irq,
  input  wire dma_size_pkg::chan_t         xferStrobe,
  input  wire dma_size_pkg::chan_t         xferRequest,
  input  wire dma_size_pkg::chan_t         totalEnd,
  input  wire logic                        addrError,
  output dma_size_pkg::chan_t              xferEnable,
  output dma_size_pkg::chan_t              channelActive,
  output dma_size_pkg::chan_t              startPulse,
  output dma_size_pkg::chan_t              blockDone,
  output dma_size_pkg::chan_field_t        accessWidth,
  output dma_size_pkg::chan_field_t        modeSelect
);
  import dma_size_pkg::*;

  ctrl_state_s q;
  ctrl_state_s d;

  logic                    busReq;
  logic                    busDone;
  logic [31:0]             beMask;
  chan_t                   blkEvt;
  logic [NUM_CH-1:0][31:0] sizeVal;
  chan_t                   sizeWr;

  assign busReq  = read | write;
  assign busDone = busReq & ~q.waitReq;
  assign beMask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  // ==========================================================
  // Per-channel size counters
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      size_counter_if sizeBus ();

      assign sizeWr[ch]             = write && busDone &&
                                      address == ((ch == 0) ? `OFS_SIZE0 : `OFS_SIZE1);
      assign sizeBus.wrEn           = sizeWr[ch];
      assign sizeBus.be             = byteenable;
      assign sizeBus.wrData         = writedata;
      assign sizeBus.running        = q.mode[ch][`B_ENABLE];
      assign sizeBus.countOn        = q.act[ch] &&
        q.mode[ch][`B_MODE +: 2] != MdNormal;
      assign sizeBus.strobe         = xferStrobe[ch];
      assign sizeVal[ch]            = sizeBus.value;
      assign blkEvt[ch]             = sizeBus.blockEnd;

      block_size_unit u_size
      (
        .clock (clock),
        .rst_b (rst_b),
        .sz    (sizeBus)
      );
    end
  endgenerate

  // ==========================================================
  // Mode readback with reserved bits forced low
  function automatic logic [31:0] modeView(input ctrl_state_s s, input int ch);
    logic [31:0] v;
    v                = s.mode[ch] & `MODE_WMASK;
    v[`B_RUNNING]    = s.act[ch];
    v[`B_XFER_END]   = s.flag[ch][0];
    v[`B_SIZE_END]   = s.flag[ch][1];
    v[`B_ERROR]      = (ch == 0) ? s.flag[ch][2] : 1'b0;
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic        wrMode;
    logic        rdMode;
    logic [31:0] m;
    logic [2:0]  evt;
    logic [31:0] ofsMode;
    logic [31:0] rdMux;
    logic        isAuto;
    logic        inBlock;
    wrMode  = 1'b0;
    rdMode  = 1'b0;
    m       = 32'h00000000;
    evt     = 3'h0;
    ofsMode = 32'h00000000;
    rdMux   = 32'h00000000;
    isAuto  = 1'b0;
    inBlock = 1'b0;
    d       = q;

    // Bus: one wait cycle, answer in the second cycle
    d.waitReq = !(busReq && q.waitReq);
    case (address)
      `OFS_SIZE0:    rdMux = sizeVal[0];
      `OFS_MODE0:    rdMux = modeView(q, 0);
      `OFS_SIZE1:    rdMux = sizeVal[1];
      `OFS_MODE1:    rdMux = modeView(q, 1);
      `OFS_IRQ_STAT: rdMux = {26'h0, q.irqStat};
      `OFS_IRQ_MASK: rdMux = {26'h0, q.irqMask};
      default:       rdMux = 32'h00000000;
    endcase
    if (busReq && q.waitReq)
      d.rdData = rdMux;

    if (write && busDone && address == `OFS_IRQ_MASK && byteenable[0])
      d.irqMask = writedata[5:0];
    if (read && busDone && address == `OFS_IRQ_STAT)
      d.irqStat = 6'h00;

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      ofsMode = {27'h0, (ch == 0) ? `OFS_MODE0 : `OFS_MODE1};
      wrMode  = write && busDone && {27'h0, address} == ofsMode;
      rdMode  = read && busDone && {27'h0, address} == ofsMode;
      inBlock = q.mode[ch][`B_MODE +: 2] == MdBlock;
      evt     = {(ch == 0) ? addrError : 1'b0, blkEvt[ch], totalEnd[ch]};

      if (rdMode)
        d.armed[ch] = q.flag[ch];
      if (wrMode)
      begin
        m = beMask & `MODE_WMASK;
        m[`B_ENABLE] = 1'b0;
        d.mode[ch] = (q.mode[ch] & ~m) | (writedata & m);
        if (byteenable[3])
        begin
          if (writedata[`B_ENABLE])
          begin
            d.mode[ch][`B_ENABLE] = 1'b1;
            d.stopPend[ch]        = 1'b0;
          end
          else if (inBlock && q.act[ch])
            d.stopPend[ch] = 1'b1;
          else
            d.mode[ch][`B_ENABLE] = 1'b0;
        end
        if (byteenable[2])
        begin
          if (!writedata[`B_XFER_END] && q.armed[ch][0]) d.flag[ch][0] = 1'b0;
          if (!writedata[`B_SIZE_END] && q.armed[ch][1]) d.flag[ch][1] = 1'b0;
          if (!writedata[`B_ERROR] && q.armed[ch][2])    d.flag[ch][2] = 1'b0;
        end
        d.armed[ch] = 3'h0;
      end

      // Hardware sets win over software clears
      d.flag[ch]            = d.flag[ch] | evt;
      d.irqStat[ch*3 +: 3]  = d.irqStat[ch*3 +: 3] | evt;

      if (blkEvt[ch] && q.stopPend[ch])
      begin
        d.mode[ch][`B_ENABLE] = 1'b0;
        d.stopPend[ch]        = 1'b0;
      end
      if (evt[0] || evt[2])
      begin
        d.mode[ch][`B_ENABLE] = 1'b0;
        d.stopPend[ch]        = 1'b0;
      end

      isAuto = d.mode[ch][`B_FACTOR +: 2] == `FACTOR_AUTO;
      d.act[ch] = d.mode[ch][`B_ENABLE] &&
        (q.act[ch] || isAuto || xferRequest[ch]);
      d.startPls[ch] = d.act[ch] && !q.act[ch];
      d.blkDone[ch]  = blkEvt[ch];
    end
    d.irq = |(d.irqStat & d.irqMask);
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q          <= '0;
      q.mode     <= {`MODE_RST, `MODE_RST};
      q.irqStat  <= `IRQ_RST;
      q.irqMask  <= `IRQ_RST;
      q.waitReq  <= 1'b1;
    end
    else
      q <= d;
  end

  // ==========================================================
  // Outputs
  assign readdata    = q.rdData;
  assign waitrequest = q.waitReq;
  assign irq         = q.irq;
  assign channelActive = q.act;
  assign startPulse  = q.startPls;
  assign blockDone   = q.blkDone;

  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_out
      assign xferEnable[ch]  = q.mode[ch][`B_ENABLE];
      assign accessWidth[ch] = q.mode[ch][`B_WIDTH +: 2];
      assign modeSelect[ch]  = q.mode[ch][`B_MODE +: 2];
    end
  endgenerate

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_readSizeFlag;
    read && busDone && address == `OFS_MODE0 && q.flag[0][1];
  endsequence
  sequence s_writeZeroSize;
    write && busDone && address == `OFS_MODE0 && byteenable[2] &&
    !writedata[`B_SIZE_END] && !blkEvt[0];
  endsequence

  a_flag_clear: assert property (s_readSizeFlag ##1 (!busReq [*1]) ##2 s_writeZeroSize
    |=> !q.flag[0][1])
    else $error("armed flag not cleared by zero write");
  a_flag_noarm: assert property ((s_writeZeroSize and (!q.armed[0][1] && q.flag[0][1]))
    |=> q.flag[0][1])
    else $error("flag cleared without prior read");
  a_reserved_zero: assert property ((read && busDone && address == `OFS_MODE1)
    |-> (readdata & ~`MODE_RMASK) == 32'h0 && !readdata[`B_ERROR])
    else $error("reserved mode bits read nonzero");
  a_layout_run: assert property ((read && busDone && address == `OFS_MODE0)
    |-> readdata[`B_RUNNING] == $past(q.act[0]) &&
        readdata[`B_ENABLE] == $past(q.mode[0][`B_ENABLE]))
    else $error("running or enable bit misplaced");
  a_auto_start: assert property ((write && busDone && address == `OFS_MODE0 &&
    byteenable == 4'hf && writedata[`B_ENABLE] &&
    writedata[`B_FACTOR +: 2] == `FACTOR_AUTO) |=> q.act[0] || !q.mode[0][`B_ENABLE])
    else $error("automatic request did not start at once");
  a_block_defer: assert property ((q.stopPend[0] && !blkEvt[0] && !totalEnd[0] && !addrError)
    |=> q.mode[0][`B_ENABLE])
    else $error("block mode stop taken before block end");
  a_block_stop: assert property ((q.stopPend[0] && blkEvt[0]) |=> !q.mode[0][`B_ENABLE])
    else $error("pending stop not taken at block end");
  a_reset_clear: assert property ($rose(rst_b) |-> q.mode == '0 && q.flag == '0)
    else $error("mode word not zero after reset");
endmodule

// file: testbench/xfer_partner.sv
`timescale 1ns/1ps
module xfer_partner
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire dma_size_pkg::chan_t channelActive,
  input  wire dma_size_pkg::chan_t xferEnable,
  input  wire logic                go,
  input  wire logic                goCh,
  input  wire logic [7:0]          goNum,
  input  wire logic [3:0]          gap,
  output dma_size_pkg::chan_t      xferStrobe,
  output dma_size_pkg::chan_t      xferRequest,
  output logic                     busy
);
  import dma_size_pkg::*;

  logic [7:0] left_q;
  logic [3:0] wait_q;
  logic       ch_q;

  // ==========================================================
  // Issues the pending transfers, only while the channel runs
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_q     <= 8'h00;
      wait_q     <= 4'h0;
      ch_q       <= 1'b0;
      xferStrobe <= '0;
    end
    else
    begin
      xferStrobe <= '0;
      if (go)
      begin
        left_q <= goNum;
        ch_q   <= goCh;
        wait_q <= gap;
      end
      else if (left_q != 8'h00 && channelActive[ch_q])
      begin
        if (wait_q != 4'h0)
          wait_q <= wait_q - 4'h1;
        else
        begin
          xferStrobe[ch_q] <= 1'b1;
          left_q           <= left_q - 8'h01;
          wait_q           <= gap;
        end
      end
    end
  end

  // Peripheral keeps asking while it has work and the channel is enabled
  always_comb
  begin
    xferRequest = '0;
    if (left_q != 8'h00 && xferEnable[ch_q])
      xferRequest[ch_q] = 1'b1;
  end

  assign busy = (left_q != 8'h00);
endmodule

// file: testbench/dma_block_size_and_mode_control_tb.sv
`timescale 1ns/1ps
`include "dma_size_defs.svh"
module dma_block_size_and_mode_control_tb;
  import dma_size_pkg::*;

  logic        clock, rst_b, read, write, addrError, irq, waitrequest;
  logic        go, goCh, busy;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable, gap;
  logic [7:0]  goNum;
  chan_t       xferStrobe, xferRequest, totalEnd, xferEnable;
  chan_t       channelActive, startPulse, blockDone;
  chan_field_t accessWidth, modeSelect;
  int          fails, checkCount, blk0, blk1;

  dma_block_size_and_mode_control dma_block_size_and_mode_control_i
  (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .xferStrobe(xferStrobe),
    .xferRequest(xferRequest), .totalEnd(totalEnd), .addrError(addrError),
    .xferEnable(xferEnable), .channelActive(channelActive), .startPulse(startPulse),
    .blockDone(blockDone), .accessWidth(accessWidth), .modeSelect(modeSelect)
  );
  xfer_partner xfer_partner_i
  (
    .clock(clock), .rst_b(rst_b), .channelActive(channelActive),
    .xferEnable(xferEnable), .go(go), .goCh(goCh), .goNum(goNum), .gap(gap),
    .xferStrobe(xferStrobe), .xferRequest(xferRequest), .busy(busy)
  );

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (blockDone[0] === 1'b1) blk0++;
    if (blockDone[1] === 1'b1) blk1++;
  end

  // ==========================================================
  // Helpers
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clock);
    read       <= !wr;
    write      <= wr;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    do
      @(posedge clock);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
  endtask

  task automatic xfer(input logic c, input logic [7:0] n, input logic [3:0] g);
    int k;
    k = 0;
    @(posedge clock);
    go    <= 1'b1;
    goCh  <= c;
    goNum <= n;
    gap   <= g;
    @(posedge clock);
    go <= 1'b0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (busy !== 1'b0 && k < 400);
    if (k >= 400) fails++;
    repeat (5) @(posedge clock);
  endtask

  task automatic start(input logic [4:0] a, input logic [31:0] m, input logic c);
    int k;
    k = 0;
    wr(a, m);
    while (channelActive[c] !== 1'b1 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    chk(k < 20, 1);
  endtask

  task automatic stopCh(input logic c);
    @(posedge clock);
    totalEnd[c] <= 1'b1;
    @(posedge clock);
    totalEnd <= '0;
    repeat (3) @(posedge clock);
    chk(xferEnable[c], 0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic tReset();
    for (int a = 0; a < 24; a += 4)
      rdChk(a[4:0], 32'h0);
    wr(5'h18, 32'hffffffff);
    rdChk(5'h18, 32'h0);
  endtask

  task automatic tLayout();
    wr(`OFS_MODE1, 32'h7fffffff);
    rdChk(`OFS_MODE1, 32'h6c00fbe7);
    chk({accessWidth[1], modeSelect[1], xferEnable[1]}, 5'h1e);
    wr(`OFS_MODE1, 32'h0);
  endtask

  task automatic tBlock();
    wr(`OFS_SIZE0, 32'h00030003);
    start(`OFS_MODE0, 32'h80001080, 1'b0);
    xfer(1'b0, 8'd2, 4'h0);
    rdChk(`OFS_SIZE0, 32'h00030001);
    bus(1'b1, `OFS_SIZE0, 32'h00090009, 4'hc);
    rdChk(`OFS_SIZE0, 32'h00030001);
    xfer(1'b0, 8'd1, 4'h3);
    rdChk(`OFS_SIZE0, 32'h00030003);
    chk(blk0, 1);
    xfer(1'b0, 8'd1, 4'h0);
    wr(`OFS_MODE0, 32'h00001080);
    chk(xferEnable[0], 1);
    xfer(1'b0, 8'd2, 4'h0);
    chk(xferEnable[0], 0);
    chk(blk0, 2);
  endtask

  task automatic tSizes();
    wr(`OFS_SIZE1, 32'h0);
    start(`OFS_MODE1, 32'h80002080, 1'b1);
    xfer(1'b1, 8'd1, 4'h0);
    rdChk(`OFS_SIZE1, 32'h0000ffff);
    stopCh(1'b1);
    wr(`OFS_SIZE1, 32'h00010001);
    start(`OFS_MODE1, 32'h80006080, 1'b1);
    xfer(1'b1, 8'd3, 4'h0);
    chk(blk1, 3);
    rdChk(`OFS_SIZE1, 32'h00010001);
    stopCh(1'b1);
    wr(`OFS_SIZE1, 32'h00050005);
    start(`OFS_MODE1, 32'h80000080, 1'b1);
    xfer(1'b1, 8'd2, 4'h1);
    rdChk(`OFS_SIZE1, 32'h00050005);
    chk(blk1, 3);
    stopCh(1'b1);
  endtask

  task automatic tRequest();
    wr(`OFS_MODE1, 32'h80002000);
    repeat (6) @(posedge clock);
    chk(channelActive[1], 0);
    xfer(1'b1, 8'd1, 4'h0);
    rdChk(`OFS_SIZE1, 32'h00050004);
    chk(blk1, 3);
    stopCh(1'b1);
  endtask

  task automatic tFlags();
    bus(1'b0, `OFS_MODE0, 32'h0, 4'hf);
    wr(`OFS_MODE0, 32'h0);
    bus(1'b0, `OFS_IRQ_STAT, 32'h0, 4'hf);
    wr(`OFS_IRQ_MASK, 32'h1);
    start(`OFS_MODE0, 32'h80000080, 1'b0);
    stopCh(1'b0);
    chk(irq, 1);
    wr(`OFS_MODE0, 32'h0);
    rdChk(`OFS_MODE0, 32'h00010000);
    wr(`OFS_MODE0, 32'h0);
    rdChk(`OFS_MODE0, 32'h0);
    rdChk(`OFS_IRQ_STAT, 32'h1);
    @(posedge clock);
    chk(irq, 0);
    start(`OFS_MODE0, 32'h80000080, 1'b0);
    @(posedge clock);
    addrError <= 1'b1;
    @(posedge clock);
    addrError <= 1'b0;
    repeat (3) @(posedge clock);
    chk(irq, 0);
    rdChk(`OFS_MODE0, 32'h00080080);
    rdChk(`OFS_IRQ_STAT, 32'h4);
  endtask

  initial
  begin
    rst_b      = 1'b0;
    read       = 1'b0;
    write      = 1'b0;
    address    = 5'h00;
    writedata  = 32'h0;
    byteenable = 4'h0;
    addrError  = 1'b0;
    totalEnd   = '0;
    go         = 1'b0;
    goCh       = 1'b0;
    goNum      = 8'h00;
    gap        = 4'h0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    tReset();
    tLayout();
    tBlock();
    tSizes();
    tRequest();
    tFlags();
    giveVerdict();
  end

  initial
  begin
    #200000;
    fails++;
    giveVerdict();
  end
endmodule
